/* logic/bss_regs.svh */
`ifndef BSS_REGS_SVH
`define BSS_REGS_SVH

// ----------------------------------------------------------------
// Boot source field codes
// ----------------------------------------------------------------
`define BSS_SRC_PINS       4'h0
`define BSS_SRC_PROG_FIRST 4'h1
`define BSS_SRC_QUAD       4'h2
`define BSS_SRC_MEM8       4'h3
`define BSS_SRC_MEM16      4'h4
`define BSS_SRC_MEM32      4'h5
`define BSS_SRC_USB_FIRST  4'h6
`define BSS_SRC_USB_SECOND 4'h7
`define BSS_SRC_SYNC       4'h8
`define BSS_SRC_PROG_FOURTH 4'h9
`define BSS_SRC_LAST       4'h9

// ----------------------------------------------------------------
// Strap pin patterns, pin three down to pin zero
// ----------------------------------------------------------------
`define BSS_STRAP_PROG     4'h0
`define BSS_STRAP_QUAD     4'h1
`define BSS_STRAP_MEM8     4'h2
`define BSS_STRAP_MEM16    4'h3

`endif

/* logic/bss_pkg.sv */
package bss_pkg;

  // ----------------------------------------------------------------
  // Selected boot source
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BSS_MODE_NONE,
    BSS_MODE_PROG_FIRST,
    BSS_MODE_PROG_FOURTH,
    BSS_MODE_QUAD_FLASH,
    BSS_MODE_SYNC_FLASH,
    BSS_MODE_MEM8,
    BSS_MODE_MEM16,
    BSS_MODE_MEM32,
    BSS_MODE_USB_FIRST,
    BSS_MODE_USB_SECOND
  } bss_mode_t;

  // ----------------------------------------------------------------
  // Pin function set for serial flash boot
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSS_PINFN_DEFAULT,
    BSS_PINFN_QUAD,
    BSS_PINFN_SYNC
  } bss_pinfn_t;

endpackage : bss_pkg

/* logic/bss_boot_source_selector.sv */
`timescale 1ns/1ps
`include "bss_regs.svh"

// Overview of operation
// [R1] Source decoding applies only when the boot enable strap is low at reset.
// [R2] An unprogrammed fuse array or a zero field hands the choice to the four strap pins.
// [R3] Field 0001 selects programming on the first serial port, 1001 on the fourth.
// [R4] Field 0010 selects quad flash boot, 1000 classic flash on sync serial port zero.
// [R5] Fields 0011, 0100 and 0101 select static memory on chip select zero at 8, 16, 32 bits.
// [R6] Field 0110 selects the first USB port and 0111 the second.
// [R7] Strap patterns LLLL, LLLH, LLHL and LLHH select programming, quad flash, 8 and 16 bits.
// [R8] The pin function set for quad flash and for sync serial flash is driven at reset.
// [R9] Field values 1010 to 1111 fall back to strap decoding like zero.

module bss_boot_source_selector (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Fuse array
  input  wire logic              otp_programmed,
  input  wire logic [3:0]        boot_source_field,
  // Board straps
  input  wire logic              boot_enable_strap,
  input  wire logic              strap_pin_three,
  input  wire logic              strap_pin_two,
  input  wire logic              strap_pin_one,
  input  wire logic              strap_pin_zero,
  // Boot selection
  output bss_pkg::bss_mode_t     boot_mode_q,
  output bss_pkg::bss_pinfn_t    pin_function_q,
  output logic                   selectable_q,
  output logic                   from_straps_q,
  output logic                   mode_valid_q
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic                rst_meta_q;
  logic                rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Fuse field decode
  // ----------------------------------------------------------------
  logic [3:0]          strap_code_w;
  logic                field_undef_w;
  logic                fuse_unused_w;
  logic                capture_w;
  bss_pkg::bss_mode_t  fuse_mode_w;
  bss_pkg::bss_mode_t  strap_mode_w;
  bss_pkg::bss_mode_t  sel_mode_w;
  bss_pkg::bss_pinfn_t pinfn_w;

  assign field_undef_w = boot_source_field > `BSS_SRC_LAST; // R9
  assign fuse_unused_w = !otp_programmed ||
                         (boot_source_field == `BSS_SRC_PINS) ||
                         field_undef_w; // R2

  assign fuse_mode_w =
    (boot_source_field == `BSS_SRC_PROG_FIRST)  ? bss_pkg::BSS_MODE_PROG_FIRST  : // R3
    (boot_source_field == `BSS_SRC_PROG_FOURTH) ? bss_pkg::BSS_MODE_PROG_FOURTH : // R3
    (boot_source_field == `BSS_SRC_QUAD)        ? bss_pkg::BSS_MODE_QUAD_FLASH  : // R4
    (boot_source_field == `BSS_SRC_SYNC)        ? bss_pkg::BSS_MODE_SYNC_FLASH  : // R4
    (boot_source_field == `BSS_SRC_MEM8)        ? bss_pkg::BSS_MODE_MEM8        : // R5
    (boot_source_field == `BSS_SRC_MEM16)       ? bss_pkg::BSS_MODE_MEM16       : // R5
    (boot_source_field == `BSS_SRC_MEM32)       ? bss_pkg::BSS_MODE_MEM32       : // R5
    (boot_source_field == `BSS_SRC_USB_FIRST)   ? bss_pkg::BSS_MODE_USB_FIRST   : // R6
    (boot_source_field == `BSS_SRC_USB_SECOND)  ? bss_pkg::BSS_MODE_USB_SECOND  : // R6
                                                  bss_pkg::BSS_MODE_NONE;

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  assign strap_code_w = {strap_pin_three, strap_pin_two, strap_pin_one, strap_pin_zero};

  // Patterns with pin three or two high have no defined source here
  assign strap_mode_w =
    (strap_code_w == `BSS_STRAP_PROG)  ? bss_pkg::BSS_MODE_PROG_FIRST : // R7
    (strap_code_w == `BSS_STRAP_QUAD)  ? bss_pkg::BSS_MODE_QUAD_FLASH : // R7
    (strap_code_w == `BSS_STRAP_MEM8)  ? bss_pkg::BSS_MODE_MEM8       : // R7
    (strap_code_w == `BSS_STRAP_MEM16) ? bss_pkg::BSS_MODE_MEM16      : // R7
                                         bss_pkg::BSS_MODE_NONE;

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  assign sel_mode_w = boot_enable_strap ? bss_pkg::BSS_MODE_NONE : // R1
                      fuse_unused_w     ? strap_mode_w :           // R2
                                          fuse_mode_w;

  assign pinfn_w = (sel_mode_w == bss_pkg::BSS_MODE_QUAD_FLASH) ? bss_pkg::BSS_PINFN_QUAD : // R8
                   (sel_mode_w == bss_pkg::BSS_MODE_SYNC_FLASH) ? bss_pkg::BSS_PINFN_SYNC : // R8
                                                                  bss_pkg::BSS_PINFN_DEFAULT;

  // Sample once, in the first cycle after rst_sync_n release (third edge after rst_n release)
  assign capture_w = !mode_valid_q;

  // ----------------------------------------------------------------
  // Captured selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_valid_q <= 1'b0;
    end else begin
      mode_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      boot_mode_q    <= bss_pkg::BSS_MODE_NONE;
      pin_function_q <= bss_pkg::BSS_PINFN_DEFAULT;
      selectable_q   <= 1'b0;
      from_straps_q  <= 1'b0;
    end else if (capture_w) begin
      boot_mode_q    <= sel_mode_w;
      pin_function_q <= pinfn_w; // R8
      selectable_q   <= !boot_enable_strap; // R1
      from_straps_q  <= !boot_enable_strap && fuse_unused_w; // R2
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  a_enable_gate: assert property ( // R1
    capture_w && boot_enable_strap |=>
      boot_mode_q == bss_pkg::BSS_MODE_NONE && !selectable_q && !from_straps_q)
    else $error("enable strap high did not block source decoding");

  a_strap_fallback: assert property ( // R2
    capture_w && !boot_enable_strap && !otp_programmed |=>
      from_straps_q && boot_mode_q == $past(strap_mode_w))
    else $error("unprogrammed fuses did not fall back to straps");

  a_prog_ports: assert property ( // R3
    capture_w && !boot_enable_strap && otp_programmed &&
    (boot_source_field == 4'h1 || boot_source_field == 4'h9) |=>
      boot_mode_q == (($past(boot_source_field) == 4'h1) ?
        bss_pkg::BSS_MODE_PROG_FIRST : bss_pkg::BSS_MODE_PROG_FOURTH))
    else $error("programming port code decoded wrongly");

  a_flash_codes: assert property ( // R4
    capture_w && !boot_enable_strap && otp_programmed && boot_source_field == 4'h8 |=>
      boot_mode_q == bss_pkg::BSS_MODE_SYNC_FLASH ##1
      boot_mode_q == bss_pkg::BSS_MODE_SYNC_FLASH)
    else $error("sync serial flash code decoded wrongly");

  a_mem_widths: assert property ( // R5
    capture_w && !boot_enable_strap && otp_programmed && boot_source_field == 4'h5 |=>
      boot_mode_q == bss_pkg::BSS_MODE_MEM32 && !from_straps_q)
    else $error("32-bit static memory code decoded wrongly");

  a_usb_ports: assert property ( // R6
    capture_w && !boot_enable_strap && otp_programmed && boot_source_field[3:1] == 3'h3 |=>
      boot_mode_q == ($past(boot_source_field[0]) ?
        bss_pkg::BSS_MODE_USB_SECOND : bss_pkg::BSS_MODE_USB_FIRST))
    else $error("USB port code decoded wrongly");

  a_strap_quad: assert property ( // R7
    capture_w && !boot_enable_strap && !otp_programmed && strap_code_w == 4'h1 |=>
      boot_mode_q == bss_pkg::BSS_MODE_QUAD_FLASH)
    else $error("strap pattern LLLH did not select quad flash");

  a_pin_function: assert property ( // R8
    mode_valid_q |->
      (pin_function_q == bss_pkg::BSS_PINFN_QUAD) ==
        (boot_mode_q == bss_pkg::BSS_MODE_QUAD_FLASH) &&
      (pin_function_q == bss_pkg::BSS_PINFN_SYNC) ==
        (boot_mode_q == bss_pkg::BSS_MODE_SYNC_FLASH))
    else $error("pin function set does not match boot source");

  a_undef_field: assert property ( // R9
    capture_w && !boot_enable_strap && otp_programmed && boot_source_field > 4'h9 |=>
      from_straps_q && boot_mode_q == $past(strap_mode_w))
    else $error("undefined field value did not fall back to straps");

  a_hold_stable: assert property ( // R1
    mode_valid_q |=> $stable(boot_mode_q) && $stable(selectable_q) &&
      $stable(pin_function_q) && $stable(from_straps_q))
    else $error("boot selection changed after capture");

  a_quad_code: assert property ( // R4
    capture_w && !boot_enable_strap && otp_programmed && boot_source_field == 4'h2 |=>
      boot_mode_q == bss_pkg::BSS_MODE_QUAD_FLASH &&
      pin_function_q == bss_pkg::BSS_PINFN_QUAD)
    else $error("quad flash code decoded wrongly");

  a_mem_narrow: assert property ( // R5
    capture_w && !boot_enable_strap && otp_programmed &&
    (boot_source_field == 4'h3 || boot_source_field == 4'h4) |=>
      boot_mode_q == (($past(boot_source_field) == 4'h3) ?
        bss_pkg::BSS_MODE_MEM8 : bss_pkg::BSS_MODE_MEM16))
    else $error("narrow static memory code decoded wrongly");

  a_strap_patterns: assert property ( // R7
    capture_w && !boot_enable_strap && !otp_programmed && strap_code_w[3:2] == 2'h0 &&
    strap_code_w != 4'h1 |=>
      boot_mode_q == (($past(strap_code_w) == 4'h0) ? bss_pkg::BSS_MODE_PROG_FIRST :
                      ($past(strap_code_w) == 4'h2) ? bss_pkg::BSS_MODE_MEM8 :
                                                      bss_pkg::BSS_MODE_MEM16))
    else $error("strap pattern decoded wrongly");

  a_disabled_pins: assert property ( // R8
    capture_w && boot_enable_strap |=> pin_function_q == bss_pkg::BSS_PINFN_DEFAULT)
    else $error("pin function set changed with decoding disabled");

  a_fuse_priority: assert property ( // R2
    capture_w && !boot_enable_strap && otp_programmed &&
    boot_source_field != 4'h0 && boot_source_field <= 4'h9 |=> !from_straps_q)
    else $error("programmed field did not take priority over straps");

  c_strap_path: cover property (capture_w && !boot_enable_strap && fuse_unused_w);
  c_quad_fuse:  cover property (capture_w && !boot_enable_strap && !fuse_unused_w &&
                                fuse_mode_w == bss_pkg::BSS_MODE_QUAD_FLASH);
  c_usb_second: cover property (capture_w && sel_mode_w == bss_pkg::BSS_MODE_USB_SECOND);
  c_disabled:   cover property (capture_w && boot_enable_strap);
  c_prog_fourth: cover property (capture_w && sel_mode_w == bss_pkg::BSS_MODE_PROG_FOURTH);

endmodule : bss_boot_source_selector

/* bench/bss_env_model.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Reset logic, fuse array and board straps
// ----------------------------------------------------------------
module bss_env_model (
  // Clock and request
  input  wire logic       clk,
  input  wire logic       reset_req,
  // Values presented around reset
  input  wire logic       cfg_otp,
  input  wire logic [3:0] cfg_field,
  input  wire logic       cfg_enable,
  input  wire logic [3:0] cfg_straps,
  // Device side
  output logic            rst_n,
  output logic            otp_programmed,
  output logic [3:0]      boot_source_field,
  output logic            boot_enable_strap,
  output logic            strap_pin_three,
  output logic            strap_pin_two,
  output logic            strap_pin_one,
  output logic            strap_pin_zero,
  // Sequence finished
  output logic            done
);
  logic [4:0] cnt_q = 5'h01;
  logic       flip;

  always @(posedge clk) begin
    if (reset_req) begin
      cnt_q <= 5'h01;
    end else if (cnt_q != 5'h16) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Low for 12 cycles, capture three edges after release
  assign rst_n = (cnt_q >= 5'h0d);
  // Inputs turn over one edge after capture; they must be ignored
  assign flip = (cnt_q >= 5'h11);
  assign done = (cnt_q == 5'h16);
  assign otp_programmed = cfg_otp ^ flip;
  assign boot_source_field = cfg_field ^ {4{flip}};
  assign boot_enable_strap = cfg_enable ^ flip;
  assign {strap_pin_three, strap_pin_two, strap_pin_one, strap_pin_zero} = cfg_straps ^ {4{flip}};
endmodule : bss_env_model

/* bench/tb_boot_source_selector.sv */
`timescale 1ns/1ps

module tb_boot_source_selector;
  // ----------------------------------------------------------------
  // Row: otp,enable,selectable,from_straps | field | straps | mode | pin set
  // ----------------------------------------------------------------
  localparam logic [19:0] ROWS [17] = '{
    20'hC_2000, 20'h3_5131, 20'hB_0010, 20'hB_0360, 20'h3_0250, 20'hB_0400,
    20'hA_1310, 20'hA_2331, 20'hA_3350, 20'hA_4360, 20'hA_5370, 20'hA_6380,
    20'hA_7390, 20'hA_8342, 20'hA_9320, 20'hB_A131, 20'hB_F250};

  logic                clk = 1'b0;
  logic                reset_req = 1'b0;
  logic                cfg_otp = 1'b0;
  logic [3:0]          cfg_field = 4'h0;
  logic                cfg_enable = 1'b0;
  logic [3:0]          cfg_straps = 4'h0;
  logic                rst_n, otp, en, s3, s2, s1, s0, done;
  logic [3:0]          field;
  bss_pkg::bss_mode_t  mode;
  bss_pkg::bss_pinfn_t pinfn;
  logic                sel, fs, valid;
  int                  fail_count = 0;
  int                  comparisons = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  bss_env_model i_env (.clk(clk), .reset_req(reset_req), .cfg_otp(cfg_otp),
    .cfg_field(cfg_field), .cfg_enable(cfg_enable), .cfg_straps(cfg_straps),
    .rst_n(rst_n), .otp_programmed(otp), .boot_source_field(field),
    .boot_enable_strap(en), .strap_pin_three(s3), .strap_pin_two(s2),
    .strap_pin_one(s1), .strap_pin_zero(s0), .done(done));

  bss_boot_source_selector i_dut (.clk(clk), .rst_n(rst_n), .otp_programmed(otp),
    .boot_source_field(field), .boot_enable_strap(en), .strap_pin_three(s3),
    .strap_pin_two(s2), .strap_pin_one(s1), .strap_pin_zero(s0),
    .boot_mode_q(mode), .pin_function_q(pinfn), .selectable_q(sel),
    .from_straps_q(fs), .mode_valid_q(valid));

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic wait_done;
    // Let the restart edge settle so a stale done is not taken
    #1;
    repeat (30) begin
      if (done !== 1'b1) begin
        @(posedge clk);
        #1;
      end
    end
    chk("env done", 4'h1, {3'b000, done});
  endtask : wait_done

  task automatic start_boot(input logic [19:0] r);
    @(posedge clk);
    cfg_otp <= r[19];
    cfg_enable <= r[18];
    cfg_field <= r[15:12];
    cfg_straps <= r[11:8];
    reset_req <= 1'b1;
    @(posedge clk);
    reset_req <= 1'b0;
  endtask : start_boot

  initial begin
    wait_done();
    for (int i = 0; i < 17; i++) begin
      start_boot(ROWS[i]);
      wait_done();
      chk("boot_mode_q", ROWS[i][7:4], mode);
      chk("pin_function_q", ROWS[i][3:0], {2'b00, pinfn});
      chk("selectable_q", {3'b000, ROWS[i][17]}, {3'b000, sel});
      chk("from_straps_q", {3'b000, ROWS[i][16]}, {3'b000, fs});
      chk("mode_valid_q", 4'h1, {3'b000, valid});
    end
    // Reset in mid-run: outputs held at reset values while reset is in force
    start_boot(20'hA_5370);
    repeat (6) @(posedge clk);
    #1;
    chk("reset boot_mode_q", 4'h0, mode);
    chk("reset pin_function_q", 4'h0, {2'b00, pinfn});
    chk("reset flags", 4'h0, {1'b0, sel, fs, valid});
    // Capture falls on the third edge after release, not earlier
    repeat (8) @(posedge clk);
    #1;
    chk("mode_valid_q before capture", 4'h0, {3'b000, valid});
    @(posedge clk);
    #1;
    chk("mode_valid_q at capture", 4'h1, {3'b000, valid});
    chk("boot_mode_q at capture", 4'h7, mode);
    wait_done();
    give_verdict();
  end

  initial begin
    repeat (1500) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule : tb_boot_source_selector
